//--- core/fsl_edge_sync.sv
/*
 * two-flop synchroniser for the link clock and serial input pins, plus
 * rising and falling edge pulses of the synchronised link clock.
 * assumes the link clock phases each last at least two system cycles.
 */
`timescale 1ns/10ps
module fsl_edge_sync (
   input wire logic clk_i,
   input wire logic reset_n_i,
   input wire logic link_clock_in_i,
   input wire logic serial_in_line_i,
   output logic clk_rise_o,
   output logic clk_fall_o,
   output logic din_o
);
   // bit 0 carries the link clock, bit 1 the serial input
   // the clock bit resets low so a stopped low link clock shows no false fall after reset
   logic [1:0] meta_ff;
   logic [1:0] sync_ff;
   logic clk_old_ff;
   logic [1:0] nxt_meta;
   logic [1:0] nxt_sync;
   logic nxt_clk_old;

   always_comb begin
      nxt_meta = {serial_in_line_i, link_clock_in_i};
      nxt_sync = meta_ff;
      nxt_clk_old = sync_ff[0];
   end

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         meta_ff <= 2'h2;
         sync_ff <= 2'h2;
         clk_old_ff <= 1'b0;
      end else begin
         meta_ff <= nxt_meta;
         sync_ff <= nxt_sync;
         clk_old_ff <= nxt_clk_old;
      end
   end

   // edges are judged from the second stage onward, never the first
   assign clk_rise_o = sync_ff[0] & ~clk_old_ff;
   assign clk_fall_o = ~sync_ff[0] & clk_old_ff;
   assign din_o = sync_ff[1];

endmodule // fsl_edge_sync

//--- core/fsl_link.sv
/*
 * device-side engine of the four-wire isolated fast serial link: one
 * transmit holding byte fed by two channels, a ten-bit transmit frame shifter, an
 * eight-bit receive shifter, receive permit control and destination routing.
 * assumes the far end drives the link clock (sampled here at 200 mhz) and
 * that channel mode straps come from the configuration loader on clk_i.
 */
`timescale 1ns/10ps
module fsl_link (
   input wire logic clk_i,
   input wire logic reset_n_i,
   input wire logic cfg_a_fast_i,
   input wire logic cfg_b_fast_i,
   input wire logic mode_cmd_valid_i,
   input wire logic [7:0] mode_cmd_value_i,
   input wire fsl_pkg::fsl_byte_t tx_a_i,
   input wire fsl_pkg::fsl_byte_t tx_b_i,
   output logic tx_a_ready_o,
   output logic tx_b_ready_o,
   output fsl_pkg::fsl_rx_t rx_o,
   input wire logic rx_ready_i,
   output logic link_pins_on_b_o,
   input wire logic link_clock_in_i,
   input wire logic serial_in_line_i,
   output logic serial_out_line_o,
   output logic receive_permit_out_o
);
   import fsl_pkg::*;

   if (LINK_HALF_MIN_CYC < SAMPLER_MIN_CYC) begin : g_rate_check
      $error("system clock too slow to sample the link clock");
   end

   logic rise;
   logic fall;
   logic din;

   fsl_edge_sync u_sync (
      .clk_i(clk_i),
      .reset_n_i(reset_n_i),
      .link_clock_in_i(link_clock_in_i),
      .serial_in_line_i(serial_in_line_i),
      .clk_rise_o(rise),
      .clk_fall_o(fall),
      .din_o(din)
   );

   ////////////////////////////////////////////////////////////////////////////
   // configuration straps and bit-mode hold
   logic cfg_done_ff, nxt_cfg_done;
   logic a_fast_ff, nxt_a_fast;
   logic b_fast_ff, nxt_b_fast;
   logic engine_hold_ff, nxt_engine_hold;
   logic pins_b_ff, nxt_pins_b;
   logic link_en;

   assign link_en = (a_fast_ff | b_fast_ff) & ~engine_hold_ff;

   always_comb begin
      nxt_cfg_done = 1'b1;
      nxt_a_fast = cfg_done_ff ? a_fast_ff : cfg_a_fast_i;
      nxt_b_fast = cfg_done_ff ? b_fast_ff : cfg_b_fast_i;
      nxt_engine_hold = engine_hold_ff;
      if (mode_cmd_valid_i && mode_cmd_value_i == MODE_HOLD) begin
         nxt_engine_hold = 1'b1;
      end else if (mode_cmd_valid_i && mode_cmd_value_i == MODE_RUN) begin
         nxt_engine_hold = 1'b0;
      end
      nxt_pins_b = a_fast_ff | b_fast_ff;
   end

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         cfg_done_ff <= 1'b0;
         a_fast_ff <= 1'b0;
         b_fast_ff <= 1'b0;
         engine_hold_ff <= 1'b0;
         pins_b_ff <= 1'b0;
      end else begin
         cfg_done_ff <= nxt_cfg_done;
         a_fast_ff <= nxt_a_fast;
         b_fast_ff <= nxt_b_fast;
         engine_hold_ff <= nxt_engine_hold;
         pins_b_ff <= nxt_pins_b;
      end
   end

   assign link_pins_on_b_o = pins_b_ff;

   ////////////////////////////////////////////////////////////////////////////
   // transmit holding byte; the grant alternates so both channels get turns
   fsl_byte_t hold_ff, nxt_hold;
   logic hold_src_ff, nxt_hold_src;
   logic turn_ff, nxt_turn;
   logic rdy_a_ff, nxt_rdy_a;
   logic rdy_b_ff, nxt_rdy_b;
   logic tx_go;

   always_comb begin
      nxt_hold = hold_ff;
      nxt_hold_src = hold_src_ff;
      nxt_turn = ~turn_ff;
      nxt_hold.valid = hold_ff.valid & ~tx_go;
      // bytes are still taken while held; they simply wait here
      if (rdy_a_ff && tx_a_i.valid) begin
         nxt_hold = tx_a_i;
         nxt_hold_src = CHAN_A;
      end else if (rdy_b_ff && tx_b_i.valid) begin
         nxt_hold = tx_b_i;
         nxt_hold_src = CHAN_B;
      end
      nxt_rdy_a = ~nxt_hold.valid & a_fast_ff & (turn_ff | ~b_fast_ff);
      nxt_rdy_b = ~nxt_hold.valid & b_fast_ff & (~turn_ff | ~a_fast_ff);
   end

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         hold_ff <= '0;
         hold_src_ff <= CHAN_A;
         turn_ff <= 1'b0;
         rdy_a_ff <= 1'b0;
         rdy_b_ff <= 1'b0;
      end else begin
         hold_ff <= nxt_hold;
         hold_src_ff <= nxt_hold_src;
         turn_ff <= nxt_turn;
         rdy_a_ff <= nxt_rdy_a;
         rdy_b_ff <= nxt_rdy_b;
      end
   end

   assign tx_a_ready_o = rdy_a_ff;
   assign tx_b_ready_o = rdy_b_ff;

   ////////////////////////////////////////////////////////////////////////////
   // transmit frame shifter: launches on link clock falling edges
   fsl_tx_state_t tx_state_ff, nxt_tx_state;
   fsl_rx_state_t rx_state_ff, nxt_rx_state;
   logic [FRAME_BITS-1:0] tx_sh_ff, nxt_tx_sh;
   logic [3:0] tx_cnt_ff, nxt_tx_cnt;
   logic tx_src_ff, nxt_tx_src;
   logic out_ff, nxt_out;

   assign tx_go = fall && tx_state_ff == TX_IDLE && hold_ff.valid && link_en && rx_state_ff == RX_IDLE;

   always_comb begin
      nxt_tx_state = tx_state_ff;
      nxt_tx_sh = tx_sh_ff;
      nxt_tx_cnt = tx_cnt_ff;
      nxt_tx_src = tx_src_ff;
      nxt_out = out_ff;
      if (!link_en) begin
         nxt_tx_state = TX_IDLE;
         nxt_out = IDLE_LEVEL;
      end else if (tx_go) begin
         nxt_tx_sh = {hold_src_ff, hold_ff.data, START_LEVEL};
         nxt_tx_src = hold_src_ff;
         nxt_tx_cnt = TX_LAST_CNT;
         nxt_out = START_LEVEL;
         nxt_tx_state = TX_BUSY;
      end else if (fall && tx_state_ff == TX_BUSY) begin
         if (tx_cnt_ff != 4'h0) begin
            nxt_tx_sh = {IDLE_LEVEL, tx_sh_ff[FRAME_BITS-1:1]};
            nxt_out = tx_sh_ff[1];
            nxt_tx_cnt = tx_cnt_ff - 4'h1;
         end else begin
            nxt_out = IDLE_LEVEL;
            nxt_tx_state = TX_IDLE;
         end
      end
   end

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         tx_state_ff <= TX_IDLE;
         tx_sh_ff <= '1;
         tx_cnt_ff <= 4'h0;
         tx_src_ff <= CHAN_A;
         out_ff <= 1'b1;
      end else begin
         tx_state_ff <= nxt_tx_state;
         tx_sh_ff <= nxt_tx_sh;
         tx_cnt_ff <= nxt_tx_cnt;
         tx_src_ff <= nxt_tx_src;
         out_ff <= nxt_out;
      end
   end

   assign serial_out_line_o = out_ff;

   ////////////////////////////////////////////////////////////////////////////
   // receive frame shifter, permit and delivery; samples on rising edges
   logic [DATA_BITS-1:0] rx_sh_ff, nxt_rx_sh;
   logic [3:0] rx_cnt_ff, nxt_rx_cnt;
   logic cts_ff, nxt_cts;
   fsl_rx_t rx_out_ff, nxt_rx_out;

   always_comb begin
      nxt_rx_state = rx_state_ff;
      nxt_rx_sh = rx_sh_ff;
      nxt_rx_cnt = rx_cnt_ff;
      nxt_cts = cts_ff;
      nxt_rx_out = rx_out_ff;
      nxt_rx_out.valid = rx_out_ff.valid & ~rx_ready_i;
      if (!link_en) begin
         nxt_rx_state = RX_IDLE;
         nxt_cts = 1'b0;
      end else begin
         unique case (rx_state_ff)
            RX_IDLE: begin
               if (rise && cts_ff && din == START_LEVEL) begin
                  nxt_rx_state = RX_DATA;
                  nxt_rx_cnt = 4'h0;
               end else if (fall && !rx_out_ff.valid) begin
                  nxt_cts = 1'b1;
               end
            end
            RX_DATA: begin
               if (rise) begin
                  nxt_rx_sh = {din, rx_sh_ff[DATA_BITS-1:1]};
                  nxt_rx_cnt = rx_cnt_ff + 4'h1;
                  if (rx_cnt_ff == 4'h0) begin
                     nxt_cts = 1'b0;
                  end
                  if (rx_cnt_ff == RX_LAST_DATA) begin
                     nxt_rx_state = RX_TARGET_CHANNEL_BIT;
                  end
               end
            end
            RX_TARGET_CHANNEL_BIT: begin
               if (rise) begin
                  nxt_rx_out.valid = 1'b1;
                  nxt_rx_out.chan = fsl_route(din, a_fast_ff, b_fast_ff);
                  nxt_rx_out.data = rx_sh_ff;
                  nxt_rx_state = RX_IDLE;
               end
            end
         endcase
      end
   end

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         rx_state_ff <= RX_IDLE;
         rx_sh_ff <= '0;
         rx_cnt_ff <= 4'h0;
         cts_ff <= 1'b0;
         rx_out_ff <= '0;
      end else begin
         rx_state_ff <= nxt_rx_state;
         rx_sh_ff <= nxt_rx_sh;
         rx_cnt_ff <= nxt_rx_cnt;
         cts_ff <= nxt_cts;
         rx_out_ff <= nxt_rx_out;
      end
   end

   assign receive_permit_out_o = cts_ff;
   assign rx_o = rx_out_ff;

   ////////////////////////////////////////////////////////////////////////////
   // checks
   property p_hold_quiet;
      @(posedge clk_i) disable iff (!reset_n_i)
      engine_hold_ff |=> serial_out_line_o && !receive_permit_out_o;
   endproperty
   a_hold_quiet: assert property (p_hold_quiet) else $error("link active while held");
   property p_release;
      @(posedge clk_i) disable iff (!reset_n_i)
      (mode_cmd_valid_i && mode_cmd_value_i == MODE_RUN) |=> !engine_hold_ff;
   endproperty
   a_release: assert property (p_release) else $error("hold not released");
   property p_start_low;
      @(posedge clk_i) disable iff (!reset_n_i)
      tx_go |=> !serial_out_line_o ##1 !serial_out_line_o;
   endproperty
   a_start_low: assert property (p_start_low) else $error("start bit not low");
   property p_no_tx_in_rx;
      @(posedge clk_i) disable iff (!reset_n_i)
      (rx_state_ff != RX_IDLE && tx_state_ff == TX_IDLE) |=> serial_out_line_o;
   endproperty
   a_no_tx_in_rx: assert property (p_no_tx_in_rx) else $error("frame sent during receive");
   property p_src_bit;
      @(posedge clk_i) disable iff (!reset_n_i)
      (tx_state_ff == TX_BUSY && tx_cnt_ff == 4'h0) |-> serial_out_line_o == tx_src_ff;
   endproperty
   a_src_bit: assert property (p_src_bit) else $error("wrong source bit");
   property p_cts_drop;
      @(posedge clk_i) disable iff (!reset_n_i)
      (link_en && rx_state_ff == RX_DATA && rise && rx_cnt_ff == 4'h0) |=> !receive_permit_out_o;
   endproperty
   a_cts_drop: assert property (p_cts_drop) else $error("permit not dropped");
   property p_cts_wait;
      @(posedge clk_i) disable iff (!reset_n_i)
      (rx_out_ff.valid || rx_state_ff != RX_IDLE) |=> !$rose(receive_permit_out_o);
   endproperty
   a_cts_wait: assert property (p_cts_wait) else $error("permit rose too early");
   property p_route;
      @(posedge clk_i) disable iff (!reset_n_i)
      $rose(rx_o.valid) |-> (rx_o.chan ? b_fast_ff : a_fast_ff);
   endproperty
   a_route: assert property (p_route) else $error("byte routed to non-link channel");
   property p_disabled;
      @(posedge clk_i) disable iff (!reset_n_i)
      (cfg_done_ff && !a_fast_ff && !b_fast_ff) |=> ##1 (serial_out_line_o && !receive_permit_out_o);
   endproperty
   a_disabled: assert property (p_disabled) else $error("link active with no channel");
   property p_pins_b;
      @(posedge clk_i) disable iff (!reset_n_i)
      (a_fast_ff || b_fast_ff) |=> link_pins_on_b_o;
   endproperty
   a_pins_b: assert property (p_pins_b) else $error("pins not moved to channel b");

endmodule // fsl_link

//--- core/fsl_pkg.sv
/*
 * shared constants, carrier structs, state encodings and the channel routing
 * function of the isolated fast serial link engine.
 * assumes one 200 mhz system clock; the link clock is a sampled input.
 */
package fsl_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // frame layout
   localparam int unsigned DATA_BITS = 8;
   localparam int unsigned FRAME_BITS = DATA_BITS + 2;
   localparam logic START_LEVEL = 1'b0;
   localparam logic IDLE_LEVEL = 1'b1;
   localparam logic CHAN_A = 1'b0;
   localparam logic CHAN_B = 1'b1;
   localparam logic [3:0] TX_LAST_CNT = 4'h9;
   localparam logic [3:0] RX_LAST_DATA = 4'h7;

   ////////////////////////////////////////////////////////////////////////////
   // bit-mode command values
   localparam logic [7:0] MODE_HOLD = 8'h10;
   localparam logic [7:0] MODE_RUN = 8'h00;

   ////////////////////////////////////////////////////////////////////////////
   // timing: each link clock phase must span at least two system cycles
   localparam int unsigned CLK_PERIOD_PS = 5000;
   localparam int unsigned LINK_HALF_MIN_PS = 10000;
   localparam int unsigned LINK_HALF_MIN_CYC = (LINK_HALF_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int unsigned SAMPLER_MIN_CYC = 2;

   ////////////////////////////////////////////////////////////////////////////
   // carriers and states
   typedef struct packed {
      logic valid;
      logic [DATA_BITS-1:0] data;
   } fsl_byte_t;

   typedef struct packed {
      logic valid;
      logic chan;
      logic [DATA_BITS-1:0] data;
   } fsl_rx_t;

   typedef enum logic [1:0] {
      TX_IDLE = 2'b01,
      TX_BUSY = 2'b10
   } fsl_tx_state_t;

   typedef enum logic [2:0] {
      RX_IDLE = 3'b001,
      RX_DATA = 3'b010,
      RX_TARGET_CHANNEL_BIT = 3'b100
   } fsl_rx_state_t;

   // a byte aimed at a channel that is not in link mode falls to the other one
   function automatic logic fsl_route(input logic target_channel_bit, input logic a_en, input logic b_en);
      if (target_channel_bit == CHAN_A) begin
         return a_en ? CHAN_A : CHAN_B;
      end
      return b_en ? CHAN_B : CHAN_A;
   endfunction

endpackage

//--- dv/fsl_far.sv
/*
 * far end of the link: makes the link clock, takes the device's frames and
 * sends frames of its own.
 * assumes the device launches bits on link falls and samples on link rises.
 */
`timescale 1ns/10ps
module fsl_far (
   input wire logic link_run_i,
   input wire logic stall_i,
   input wire logic serial_out_line_i,
   input wire logic receive_permit_out_i,
   output logic link_clock_o,
   output logic serial_in_o,
   output logic [7:0] got_data_o,
   output logic got_src_o,
   output logic [7:0] got_n_o
);
   logic [3:0] cnt_ff = 4'h0;
   logic [7:0] sh_ff = 8'h00;

   initial begin
      link_clock_o = 1'b0;
      serial_in_o = 1'b1;
      got_data_o = 8'h00;
      got_src_o = 1'b0;
      got_n_o = 8'h00;
   end

   ////////////////////////////////////////////////////////////////////////////
   // clock freezes high after a start bit while we cannot take the byte
   always #40 begin
      if (link_run_i && !(stall_i && cnt_ff == 4'h1)) begin
         link_clock_o = ~link_clock_o;
      end
   end

   always @(posedge link_clock_o) begin
      if (cnt_ff == 4'h0) begin
         if (serial_out_line_i === 1'b0) begin
            cnt_ff <= 4'h1;
         end
      end else if (cnt_ff < 4'h9) begin
         sh_ff <= {serial_out_line_i, sh_ff[7:1]};
         cnt_ff <= cnt_ff + 4'h1;
      end else begin
         got_data_o <= sh_ff;
         got_src_o <= serial_out_line_i;
         got_n_o <= got_n_o + 8'h01;
         cnt_ff <= 4'h0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // the line idles high between frames, as the pull-up would leave it
   task automatic send(input logic [7:0] d, input logic dst);
      int i;
      @(negedge link_clock_o);
      while (receive_permit_out_i !== 1'b1) @(negedge link_clock_o);
      serial_in_o = 1'b0;
      for (i = 0; i < 8; i++) begin
         @(negedge link_clock_o);
         serial_in_o = d[i];
      end
      @(negedge link_clock_o);
      serial_in_o = dst;
      @(negedge link_clock_o);
      serial_in_o = 1'b1;
   endtask
endmodule // fsl_far

//--- dv/fsl_link_tb.sv
/*
 * self-checking bench of the link engine, with the far end model.
 * assumes the design files of core/ are compiled first.
 */
`timescale 1ns/10ps
module fsl_link_tb;
   import fsl_pkg::*;
   logic clk = 1'b0;
   logic reset_n = 1'b0;
   logic cfg_a = 1'b0;
   logic cfg_b = 1'b0;
   logic cmd_v = 1'b0;
   logic [7:0] cmd_val = 8'h00;
   fsl_byte_t tx_a = '0;
   fsl_byte_t tx_b = '0;
   logic rdy_a, rdy_b, pins_b, lclk, sin, sout, permit, got_s;
   fsl_rx_t rx;
   logic rx_rdy = 1'b0;
   logic run = 1'b0;
   logic stall = 1'b0;
   logic fin = 1'b0;
   logic [7:0] got_d, got_n;
   int n_tests = 0;
   int n_mismatch = 0;

   always #2.5 clk = ~clk;

   fsl_link i_fsl_link (.clk_i(clk), .reset_n_i(reset_n), .cfg_a_fast_i(cfg_a), .cfg_b_fast_i(cfg_b),
      .mode_cmd_valid_i(cmd_v), .mode_cmd_value_i(cmd_val), .tx_a_i(tx_a), .tx_b_i(tx_b),
      .tx_a_ready_o(rdy_a), .tx_b_ready_o(rdy_b), .rx_o(rx), .rx_ready_i(rx_rdy),
      .link_pins_on_b_o(pins_b), .link_clock_in_i(lclk), .serial_in_line_i(sin),
      .serial_out_line_o(sout), .receive_permit_out_o(permit));

   fsl_far i_fsl_far (.link_run_i(run), .stall_i(stall), .serial_out_line_i(sout),
      .receive_permit_out_i(permit), .link_clock_o(lclk), .serial_in_o(sin),
      .got_data_o(got_d), .got_src_o(got_s), .got_n_o(got_n));

   ////////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic test_done();
      $display("checks %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   task automatic do_reset(input logic a, input logic b);
      @(posedge clk);
      #1 run = 1'b0;
      reset_n = 1'b0;
      cfg_a = a;
      cfg_b = b;
      repeat (3) @(posedge clk);
      #1 reset_n = 1'b1;
      repeat (3) @(posedge clk);
      #1 run = 1'b1;
   endtask

   // ready is registered, so it is read at the falling edge before the taking edge
   task automatic hsend(input logic ch, input logic [7:0] d);
      int k;
      k = 0;
      @(posedge clk);
      #1 if (ch) tx_b = '{valid: 1'b1, data: d};
      else tx_a = '{valid: 1'b1, data: d};
      @(negedge clk);
      while ((ch ? rdy_b : rdy_a) !== 1'b1 && k < 4000) begin
         @(negedge clk);
         k++;
      end
      check(k >= 4000, 1'b0);
      @(posedge clk);
      #1 tx_a.valid = 1'b0;
      tx_b.valid = 1'b0;
   endtask

   task automatic wait_got(input logic [7:0] n0);
      int k;
      k = 0;
      while (got_n === n0 && k < 4000) begin
         @(posedge clk);
         k++;
      end
      check(k >= 4000, 1'b0);
   endtask

   task automatic cmd(input logic [7:0] v);
      @(posedge clk);
      #1 cmd_v = 1'b1;
      cmd_val = v;
      @(posedge clk);
      #1 cmd_v = 1'b0;
   endtask

   task automatic take_rx(input logic ch, input logic [7:0] d);
      int k;
      k = 0;
      while (rx.valid !== 1'b1 && k < 4000) begin
         @(negedge clk);
         k++;
      end
      check(k >= 4000, 1'b0);
      check({rx.chan, rx.data}, {ch, d});
      #400 check({rx.valid, permit}, 2'b10);
      @(posedge clk);
      #1 rx_rdy = 1'b1;
      @(posedge clk);
      #1 rx_rdy = 1'b0;
      #400 check(permit, 1'b1);
   endtask

   ////////////////////////////////////////////////////////////////////////////
   task automatic t_pins();
      int i;
      for (i = 0; i < 4; i++) begin
         do_reset(i[0], i[1]);
         check(pins_b, i != 0);
      end
      do_reset(1'b0, 1'b0);
      cfg_a = 1'b1;
      cfg_b = 1'b1;
      tx_a = '{valid: 1'b1, data: 8'h77};
      #800 check({pins_b, rdy_a, sout}, 3'b001);
      tx_a.valid = 1'b0;
      $display("test pins done");
   endtask

   task automatic t_tx();
      logic [7:0] n0;
      do_reset(1'b1, 1'b1);
      n0 = got_n;
      hsend(1'b0, 8'ha5);
      hsend(1'b1, 8'h3c);
      wait_got(n0);
      check({got_s, got_d}, {1'b0, 8'ha5});
      wait_got(n0 + 8'h01);
      check({got_s, got_d}, {1'b1, 8'h3c});
      $display("test tx done");
   endtask

   task automatic t_hold();
      logic [7:0] n0;
      n0 = got_n;
      cmd(MODE_HOLD);
      hsend(1'b1, 8'h5a);
      #1600 check({got_n, 7'h00, sout}, {n0, 8'h01});
      cmd(MODE_RUN);
      wait_got(n0);
      check({got_s, got_d}, {1'b1, 8'h5a});
      $display("test hold done");
   endtask

   task automatic t_stall();
      logic [7:0] n0;
      n0 = got_n;
      stall = 1'b1;
      hsend(1'b0, 8'h69);
      #2000 check({got_n, 7'h00, lclk}, {n0, 8'h01});
      stall = 1'b0;
      wait_got(n0);
      check({got_s, got_d}, {1'b0, 8'h69});
      $display("test stall done");
   endtask

   task automatic t_rx();
      logic [3:0] cases [4] = '{4'b1100, 4'b1111, 4'b0101, 4'b1010};
      int i;
      for (i = 0; i < 4; i++) begin
         do_reset(cases[i][3], cases[i][2]);
         #400;
         fork
            i_fsl_far.send(8'h96 ^ i[7:0], cases[i][1]);
            begin
               @(negedge sin);
               @(posedge lclk);
               @(posedge lclk);
               repeat (6) @(posedge clk);
               #1 check(permit, 1'b0);
            end
         join
         take_rx(cases[i][0], 8'h96 ^ i[7:0]);
      end
      $display("test rx done");
   endtask

   task automatic t_busy();
      logic [7:0] n0;
      do_reset(1'b1, 1'b1);
      n0 = got_n;
      fin = 1'b0;
      fork
         begin
            i_fsl_far.send(8'h0f, 1'b0);
            fin = 1'b1;
         end
         begin
            @(negedge sin);
            @(posedge lclk);
            @(posedge lclk);
            hsend(1'b1, 8'h11);
            while (fin !== 1'b1) begin
               @(posedge clk);
               #1 if (sout !== 1'b1) check(sout, 1'b1);
            end
         end
      join
      wait_got(n0);
      check({got_s, got_d}, {1'b1, 8'h11});
      take_rx(1'b0, 8'h0f);
      $display("test busy done");
   endtask

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      #100000;
      n_mismatch++;
      $display("CHECK FAILED at %0t: watchdog ran out", $time);
      test_done();
   end

   initial begin
      t_pins();
      t_tx();
      t_hold();
      t_stall();
      t_rx();
      t_busy();
      test_done();
   end
endmodule // fsl_link_tb
